// [hw/spf_pkg.sv]
package spf_pkg;
  // Register map, byte address on APB
  localparam logic [7:0] SPF_CTRL_OFS = 8'h00;
  localparam logic [7:0] SPF_ZPTR_OFS = 8'h04;
  localparam logic [7:0] SPF_SRC_OFS = 8'h08;
  localparam logic [7:0] SPF_CORE_OFS = 8'h0C;
  localparam logic [7:0] SPF_STAT_OFS = 8'h10;
  localparam logic [7:0] SPF_LOCK_OFS = 8'h14;
  localparam logic [7:0] SPF_PAGE_OFS = 8'h18;
  // Control register bit positions
  localparam int SPF_B_IRQ_EN = 7;
  localparam int SPF_B_BUSY = 6;
  localparam int SPF_B_RESV = 5;
  localparam int SPF_B_RD_EN = 4;
  localparam int SPF_B_LOCK = 3;
  localparam int SPF_B_PGWR = 2;
  localparam int SPF_B_PGER = 1;
  localparam int SPF_B_STEN = 0;
  // Core control register bit positions
  localparam int SPF_B_STORE = 0;
  localparam int SPF_B_LOAD = 1;
  localparam int SPF_B_GIE = 2;
  localparam int SPF_B_STALLING_SECTION = 3;
  // Accepted command patterns in the low five bits
  localparam logic [4:0] SPF_CMD_RDEN = 5'h11;
  localparam logic [4:0] SPF_CMD_LOCK = 5'h09;
  localparam logic [4:0] SPF_CMD_PGWR = 5'h05;
  localparam logic [4:0] SPF_CMD_PGER = 5'h03;
  localparam logic [4:0] SPF_CMD_LOAD = 5'h01;
  // Reset values
  localparam logic [7:0] SPF_CTRL_RST = 8'h00;
  localparam logic [7:0] SPF_LOCK_RST = 8'hFF;
  localparam logic [15:0] SPF_APP_VEC = 16'h0000;
  // Windows in cycles
  localparam logic [2:0] SPF_STORE_WIN = 3'd4;
  localparam logic [2:0] SPF_LOAD_WIN = 3'd3;
  // Flash array operation time
  localparam int SPF_PROG_NS = 200;
  localparam int SPF_CLK_NS = 20;
  localparam int SPF_PROG_CYC = (SPF_PROG_NS + SPF_CLK_NS - 1) / SPF_CLK_NS;
  // Unmapped read value
  localparam logic [31:0] SPF_UNMAPPED = 32'h0000_0000;
endpackage

// [hw/spf_page_buf.sv]
`timescale 1ns/1ns
// Temporary page buffer: write one word, clear all at once
module spf_page_buf #(
  parameter int WORDS = 32,
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write side
  input wire logic wr,
  input wire logic [AW-1:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic clr,
  // Read side
  input wire logic [AW-1:0] raddr,
  output logic [15:0] rdata
);
  // Storage array, erased state all ones
  logic [15:0] mem [WORDS];

  // Elaboration check: the word index must cover the array exactly
  if (WORDS != (1 << AW)) begin : g_bad_depth
    $error("page buffer depth must be 2**AW");
  end

  // Clear takes priority so an aborted load leaves nothing behind
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < WORDS; i++) mem[i] <= 16'hFFFF;
    end else if (clr) begin
      for (int i = 0; i < WORDS; i++) mem[i] <= 16'hFFFF;
    end else if (wr) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

// [hw/spf_ctrl.sv]
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module spf_ctrl
  import spf_pkg::*;
#(
  parameter int PAGE_W = 5,
  parameter int PROG_CYC = spf_pkg::SPF_PROG_CYC,
  parameter logic [15:0] BOOT_VEC = 16'h0C00,
  parameter logic [7:0] FUSE_LOW = 8'hE1 // Arbitrary neutral value
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fuse pin
  input wire logic boot_reset_select,
  // Core side
  output logic [15:0] reset_vector,
  output logic ready_irq,
  output logic core_stall,
  output logic section_read_block,
  output logic [7:0] load_data,
  output logic load_data_valid
);
  import spf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  // Buffer read index comes from the 8-bit bus address, so pages stay small
  if (PAGE_W < 1 || PAGE_W > 6) begin : g_bad_page
    $error("PAGE_W out of range");
  end
  // Timer is 16 bits wide and a zero length would never start
  if (PROG_CYC < 1 || PROG_CYC > 65535) begin : g_bad_prog
    $error("PROG_CYC out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and fuse synchroniser
  // Flops below reset at once but leave reset on a clock edge,
  // so no register sees a release that races the clock
  logic [1:0] rst_sync_q; // Release chain
  logic rst_n; // Internal reset copy
  logic [1:0] fuse_sync_q; // Fuse pin sync

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  // Second stage is the only one anyone reads
  assign rst_n = rst_sync_q[1];

  // Fuse is only observed, never written here
  // Two flops, because the pin may move at any time relative to mclk
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fuse_sync_q <= 2'b11;
    end else begin
      fuse_sync_q <= {fuse_sync_q[0], boot_reset_select};
    end
  end

  // Vector choice, held in a flop
  // Registered so the vector never glitches while the pin settles
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reset_vector <= SPF_APP_VEC;
    end else begin
      reset_vector <= fuse_sync_q[1] ? SPF_APP_VEC : BOOT_VEC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  // Everything the core does arrives as a bus write
  logic wr_en; // Write accepted this cycle
  logic rd_en; // Read accepted this cycle
  logic [7:0] ctrl_q; // Control register
  logic [15:0] zptr_q; // Address pointer
  logic [15:0] src_q; // High:low source pair
  logic gie_q; // Global interrupt flag
  logic stall_sect_q; // Target page is in stalling section
  logic [7:0] lock_q; // Boot lock bits
  logic [2:0] win_q; // Shared window down-counter
  logic [2:0] lwin_q; // Load-read window
  logic [15:0] prog_cnt_q; // Array operation timer
  logic prog_busy; // Erase or write running
  logic [15:0] page_addr_q; // Latched flash address
  logic [4:0] cmd; // Low five bits written
  logic ctrl_wr; // Control register write
  logic cmd_ok; // Write is a legal pattern
  logic store_go; // Store issued in window
  logic load_go; // Load issued in window
  logic [15:0] buf_rdata; // Buffer read port, not on the bus map
  logic op_start; // Erase or write accepted this cycle
  logic stall_op_q; // Running operation halts the core

  // Zero-wait slave, never errors
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign cmd = pwdata[4:0];
  assign ctrl_wr = wr_en && paddr == SPF_CTRL_OFS;

  // Legal command check
  // Any other low-five pattern is dropped whole, bit 7 aside
  function automatic logic legal_cmd(input logic [4:0] c);
    legal_cmd = (c == SPF_CMD_RDEN) || (c == SPF_CMD_LOCK) || (c == SPF_CMD_PGWR)
      || (c == SPF_CMD_PGER) || (c == SPF_CMD_LOAD);
  endfunction

  // New commands only when idle
  assign cmd_ok = ctrl_wr && legal_cmd(cmd) && !ctrl_q[SPF_B_STEN];
  // Core strobes through the core register
  // A strobe after its window has closed is simply dropped
  assign store_go = wr_en && paddr == SPF_CORE_OFS && pwdata[SPF_B_STORE] &&
    ctrl_q[SPF_B_STEN] && win_q != 3'd0 && !prog_busy;
  assign load_go = wr_en && paddr == SPF_CORE_OFS && pwdata[SPF_B_LOAD] &&
    ctrl_q[SPF_B_LOCK] && ctrl_q[SPF_B_STEN] && lwin_q != 3'd0;
  assign prog_busy = prog_cnt_q != 16'h0000;
  // Erase or write start; the section choice rides on the same strobe
  assign op_start = store_go &&
    (ctrl_q[SPF_B_PGWR] || ctrl_q[SPF_B_PGER]);

  ////////////////////////////////////////////////////////////////////////////
  // Pointer, source, core flags
  // Plain storage; writes land at the access edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      zptr_q <= 16'h0000;
      src_q <= 16'h0000;
      gie_q <= 1'b0;
      stall_sect_q <= 1'b0;
    end else if (wr_en) begin
      if (paddr == SPF_ZPTR_OFS) zptr_q <= pwdata[15:0];
      if (paddr == SPF_SRC_OFS) src_q <= pwdata[15:0];
      if (paddr == SPF_CORE_OFS) begin
        gie_q <= pwdata[SPF_B_GIE];
        stall_sect_q <= pwdata[SPF_B_STALLING_SECTION];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window counters, started the cycle after the write
  // Loaded on the write edge, so the first strobe may come one edge later
  // Any accepted strobe closes both windows at once
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      win_q <= 3'd0;
      lwin_q <= 3'd0;
    end else if (cmd_ok) begin
      win_q <= SPF_STORE_WIN;
      lwin_q <= (cmd == SPF_CMD_LOCK) ? SPF_LOAD_WIN : 3'd0;
    end else if (store_go || load_go) begin
      win_q <= 3'd0;
      lwin_q <= 3'd0;
    end else begin
      if (win_q != 3'd0) win_q <= win_q - 3'd1;
      if (lwin_q != 3'd0) lwin_q <= lwin_q - 3'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array operation timer and latched address
  // Address and stall choice are captured at the start, so the core may
  // reuse the pointer and the core register while the array is busy
  // Counts down to zero; its last count also ends the command bits
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prog_cnt_q <= 16'h0000;
      page_addr_q <= 16'h0000;
      stall_op_q <= 1'b0;
    end else if (op_start) begin
      prog_cnt_q <= PROG_CYC[15:0];
      stall_op_q <= pwdata[SPF_B_STALLING_SECTION];
      // Page field from upper pointer bits only
      page_addr_q <= {zptr_q[15:PAGE_W+1], {(PAGE_W+1){1'b0}}};
    end else if (prog_busy) begin
      prog_cnt_q <= prog_cnt_q - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register with self-clearing bits
  // Bit 7 is plain storage, written by any control write
  // Command bits: loaded by a legal write, cleared on completion or timeout
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= SPF_CTRL_RST;
    end else begin
      if (ctrl_wr) ctrl_q[SPF_B_IRQ_EN] <= pwdata[SPF_B_IRQ_EN];
      if (cmd_ok) begin
        ctrl_q[4:0] <= cmd;
      end else if (store_go) begin
        // Erase and write hold their bits until the array is done
        if (ctrl_q[SPF_B_PGWR] || ctrl_q[SPF_B_PGER]) begin
          ctrl_q[4:0] <= ctrl_q[4:0];
        end else begin
          ctrl_q[4:0] <= 5'h00;
        end
      end else if (load_go) begin
        ctrl_q[4:0] <= 5'h00;
      end else if (prog_cnt_q == 16'h0001) begin
        ctrl_q[4:0] <= 5'h00;
      end else if (!prog_busy && win_q == 3'd1) begin
        ctrl_q[4:0] <= 5'h00;
      end
      // Busy flag: set on a start outside the stalling section, cleared by load or re-enable
      // Set only by hardware; a clear in the same cycle loses
      // Written section bit, not the stored one: both land on the same edge
      if (op_start && !pwdata[SPF_B_STALLING_SECTION]) begin
        ctrl_q[SPF_B_BUSY] <= 1'b1;
      end else if (store_go && ctrl_q[4:0] == SPF_CMD_LOAD) begin
        ctrl_q[SPF_B_BUSY] <= 1'b0;
      end else if (store_go && ctrl_q[4:0] == SPF_CMD_RDEN) begin
        ctrl_q[SPF_B_BUSY] <= 1'b0;
      end
      ctrl_q[SPF_B_RESV] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot lock bits, only ever programmed toward zero
  // Only reset can return a bit to the unprogrammed state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= SPF_LOCK_RST;
    end else if (store_go && ctrl_q[4:0] == SPF_CMD_LOCK) begin
      // Pointer and high source are ignored here
      lock_q[5:2] <= lock_q[5:2] & src_q[5:2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock or fuse read result
  // Lock bits when pointer bit 0 is set, fuse byte otherwise
  // Pulse marks the cycle after the strobe; data stays until the next load
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      load_data <= 8'h00;
      load_data_valid <= 1'b0;
    end else begin
      load_data_valid <= load_go;
      if (load_go) load_data <= zptr_q[0] ? lock_q : FUSE_LOW;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer; a read-enable write while loading discards data
  // Abort clears the words but leaves the pending load command armed
  logic buf_wr; // Word load
  logic buf_clr; // Whole-buffer clear
  assign buf_wr = store_go && ctrl_q[4:0] == SPF_CMD_LOAD;
  assign buf_clr = (prog_cnt_q == 16'h0001 && ctrl_q[SPF_B_PGWR]) ||
    (cmd_ok && cmd == SPF_CMD_RDEN) ||
    (ctrl_wr && pwdata[SPF_B_RD_EN] && ctrl_q[4:0] == SPF_CMD_LOAD);

  // Word index skips pointer bit 0; the page field starts above it
  spf_page_buf #(
    .WORDS(1 << PAGE_W),
    .AW(PAGE_W)
  ) u_buf (
    .clk(mclk),
    .rst_n(rst_n),
    .wr(buf_wr),
    .waddr(zptr_q[PAGE_W:1]),
    .wdata(src_q),
    .clr(buf_clr),
    .raddr(paddr[PAGE_W+1:2]),
    .rdata(buf_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Core-facing status
  assign ready_irq = ctrl_q[SPF_B_IRQ_EN] && gie_q && !ctrl_q[SPF_B_STEN];
  assign section_read_block = ctrl_q[SPF_B_BUSY];
  // Stall lasts exactly as long as the array timer runs
  assign core_stall = prog_busy && stall_op_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB read mux, registered
  // Loaded in the setup cycle so the data stands through the access phase
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= SPF_UNMAPPED;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        SPF_CTRL_OFS: prdata <= {24'h0000_00, ctrl_q};
        SPF_ZPTR_OFS: prdata <= {16'h0000, zptr_q};
        SPF_SRC_OFS: prdata <= {16'h0000, src_q};
        SPF_CORE_OFS: prdata <= {28'h000_0000, stall_sect_q, gie_q, 2'b00};
        SPF_STAT_OFS: prdata <= {16'h0000, prog_cnt_q};
        SPF_LOCK_OFS: prdata <= {16'h0000, load_data, lock_q};
        SPF_PAGE_OFS: prdata <= {16'h0000, page_addr_q};
        default: prdata <= SPF_UNMAPPED;
      endcase
    end
  end

  // Buffer word view is not on the bus map; keeps read port exercised
  // Reduced to one bit so no part of the read port is left dangling
  logic unused_buf;
  assign unused_buf = ^buf_rdata & rd_en;
endmodule

// [dv/spf_ctrl_assertions.sv]
`timescale 1ns/1ns
// Port-level checks on the self-programming controller
module spf_ctrl_assertions
  import spf_pkg::*;
#(
  parameter int PROG_CYC = 10,
  parameter logic [15:0] BOOT_VEC = 16'h0C00
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // Fuse and core side
  input wire logic boot_reset_select,
  input wire logic [15:0] reset_vector,
  input wire logic ready_irq,
  input wire logic core_stall,
  input wire logic load_data_valid
);
  // Slack covers the start and end edges of a stalled operation
  localparam int STALL_MAX = PROG_CYC + 6;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Fuse steady long enough to pass reset release and the synchroniser
  sequence s_fuse_app;
    boot_reset_select[*8];
  endsequence
  sequence s_fuse_boot;
    !boot_reset_select[*8];
  endsequence
  // A stalled operation never ends sooner than eight cycles
  sequence s_stall_run;
    core_stall[*8];
  endsequence
  a_vector_app: assert property (s_fuse_app |-> reset_vector == 16'h0000)
    else $error("reset vector not application start");
  a_vector_boot: assert property (s_fuse_boot |-> reset_vector == BOOT_VEC)
    else $error("reset vector not loader start");
  a_no_slverr: assert property (psel && penable |-> !pslverr)
    else $error("slave error raised");
  a_load_pulse: assert property (load_data_valid |=> !load_data_valid)
    else $error("load valid longer than one cycle");
  a_load_cause: assert property (load_data_valid |->
      $past(psel && penable && pwrite && paddr == SPF_CORE_OFS && pwdata[SPF_B_LOAD]))
    else $error("load valid without load strobe");
  a_stall_no_irq: assert property (core_stall |-> !ready_irq)
    else $error("ready interrupt during stalled operation");
  a_stall_hold: assert property ($rose(core_stall) |-> s_stall_run)
    else $error("stall ended too early");
  a_stall_end: assert property ($rose(core_stall) |-> ##[1:STALL_MAX] !core_stall)
    else $error("stall never ended");
endmodule
bind spf_ctrl spf_ctrl_assertions #(.PROG_CYC(PROG_CYC), .BOOT_VEC(BOOT_VEC)) i_spf_ctrl_assertions (
  .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pslverr(pslverr), .boot_reset_select(boot_reset_select),
  .reset_vector(reset_vector), .ready_irq(ready_irq), .core_stall(core_stall),
  .load_data_valid(load_data_valid));

// [dv/spf_core_bfm.sv]
`timescale 1ns/1ns
// Core model: reaches registers and strobes over APB
module spf_core_bfm
  import spf_pkg::*;
(
  // Clock
  mclk,
  // APB master side
  psel, penable, pwrite, paddr, pwdata, prdata, pready
);
  input wire logic mclk;
  output logic psel;
  output logic penable;
  output logic pwrite;
  output logic [7:0] paddr;
  output logic [31:0] pwdata;
  input wire logic [31:0] prdata;
  input wire logic pready;
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // Setup, then access held until pready seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Command, then the strobe three edges later, inside the window
  task automatic cmd(input logic [7:0] c, input logic [3:0] core);
    logic [31:0] q;
    xfer(1'b1, SPF_CTRL_OFS, {24'h00_0000, c}, q);
    xfer(1'b1, SPF_CORE_OFS, {28'h000_0000, core}, q);
  endtask
endmodule

// [dv/tb.sv]
`timescale 1ns/1ns
// Self-checking bench for the self-programming controller
module tb;
  import spf_pkg::*;
  localparam logic [15:0] BOOT_VEC = 16'h0C00;
  localparam logic [7:0] FUSE_LOW = 8'hE1; // Arbitrary fuse byte
  // Clock, reset, fuse
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic boot_reset_select = 1'b1;
  // Bus and core side
  logic psel, penable, pwrite, pready, pslverr, ready_irq, core_stall;
  logic section_read_block, load_data_valid;
  logic [7:0] paddr, load_data;
  logic [31:0] pwdata, prdata;
  logic [15:0] reset_vector;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  always #10 mclk = ~mclk;
  spf_ctrl #(.PAGE_W(5), .PROG_CYC(10), .BOOT_VEC(BOOT_VEC), .FUSE_LOW(FUSE_LOW)) i_spf_ctrl (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_reset_select(boot_reset_select), .reset_vector(reset_vector), .ready_irq(ready_irq),
    .core_stall(core_stall), .section_read_block(section_read_block), .load_data(load_data),
    .load_data_valid(load_data_valid));
  spf_core_bfm i_spf_core_bfm (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, far above the run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_spf_core_bfm.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_spf_core_bfm.xfer(1'b0, a, 32'h0000_0000, q);
    chk("register", q, e);
  endtask
  // Poll until store enable drops, bounded
  task automatic wait_idle();
    logic [31:0] q;
    q = 32'h0000_0001;
    for (int i = 0; i < 40 && q[SPF_B_STEN] !== 1'b0; i++) begin
      i_spf_core_bfm.xfer(1'b0, SPF_CTRL_OFS, 32'h0000_0000, q);
    end
  endtask
  // Wait for the one-cycle load pulse at falling edges, then compare masked data
  task automatic wait_load(input logic [7:0] e, input logic [7:0] m);
    @(negedge mclk);
    for (int i = 0; i < 4 && load_data_valid !== 1'b1; i++) begin
      @(negedge mclk);
    end
    chk("load_valid", {31'h0, load_data_valid}, 32'h0000_0001);
    chk("load_data", {24'h00_0000, load_data & m}, {24'h00_0000, e});
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset_vec();
    rd(SPF_CTRL_OFS, 32'h0000_0000);
    rd(8'h1C, SPF_UNMAPPED);
    chk("reset_vector", {16'h0000, reset_vector}, 32'h0000_0000);
    @(posedge mclk);
    boot_reset_select <= 1'b0;
    repeat (9) @(posedge mclk);
    #1 chk("reset_vector", {16'h0000, reset_vector}, {16'h0000, BOOT_VEC});
    @(posedge mclk);
    boot_reset_select <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk("reset_vector", {16'h0000, reset_vector}, 32'h0000_0000);
  endtask
  // Illegal pattern, reserved bit, interrupt level
  task automatic t_filter_irq();
    wr(SPF_CORE_OFS, 32'h0000_0004);
    wr(SPF_CTRL_OFS, 32'h0000_00A7);
    rd(SPF_CTRL_OFS, 32'h0000_0080);
    chk("ready_irq", {31'h0, ready_irq}, 32'h0000_0001);
    wr(SPF_CTRL_OFS, 32'h0000_0081);
    #1 chk("ready_irq", {31'h0, ready_irq}, 32'h0000_0000);
    repeat (5) @(posedge mclk);
    rd(SPF_CTRL_OFS, 32'h0000_0080);
    chk("ready_irq", {31'h0, ready_irq}, 32'h0000_0001);
    wr(SPF_CTRL_OFS, 32'h0000_0000);
  endtask
  // Every command left to time out, then a late strobe
  task automatic t_timeout();
    logic [7:0] cmds [5] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h11};
    foreach (cmds[k]) begin
      wr(SPF_CTRL_OFS, {24'h00_0000, cmds[k]});
      repeat (5) @(posedge mclk);
      wr(SPF_CORE_OFS, 32'h0000_0001);
      rd(SPF_CTRL_OFS, 32'h0000_0000);
    end
    rd(SPF_LOCK_OFS, 32'h0000_00FF);
    rd(SPF_STAT_OFS, 32'h0000_0000);
  endtask
  // Busy flag set, refused re-enable, cleared by load and re-enable
  task automatic t_busy();
    wr(SPF_ZPTR_OFS, 32'h0000_0140);
    i_spf_core_bfm.cmd(8'h03, 4'h1);
    rd(SPF_CTRL_OFS, 32'h0000_0043);
    chk("read_block", {31'h0, section_read_block}, 32'h0000_0001);
    wr(SPF_ZPTR_OFS, 32'h0000_0000);
    rd(SPF_PAGE_OFS, 32'h0000_0140);
    wr(SPF_CTRL_OFS, 32'h0000_0011);
    wait_idle();
    rd(SPF_CTRL_OFS, 32'h0000_0040);
    i_spf_core_bfm.cmd(8'h01, 4'h1);
    rd(SPF_CTRL_OFS, 32'h0000_0000);
    wr(SPF_ZPTR_OFS, 32'h0000_0140);
    i_spf_core_bfm.cmd(8'h05, 4'h1);
    wait_idle();
    rd(SPF_CTRL_OFS, 32'h0000_0040);
    i_spf_core_bfm.cmd(8'h11, 4'h1);
    rd(SPF_CTRL_OFS, 32'h0000_0000);
    chk("read_block", {31'h0, section_read_block}, 32'h0000_0000);
    i_spf_core_bfm.cmd(8'h03, 4'h9);
    repeat (2) @(posedge mclk);
    #1 chk("core_stall", {31'h0, core_stall}, 32'h0000_0001);
    wait_idle();
    rd(SPF_CTRL_OFS, 32'h0000_0000);
  endtask
  // Lock set from source bits, then lock and fuse reads
  task automatic t_lock();
    wr(SPF_SRC_OFS, 32'h0000_00F3);
    i_spf_core_bfm.cmd(8'h09, 4'h1);
    wait_idle();
    rd(SPF_CTRL_OFS, 32'h0000_0000);
    wr(SPF_ZPTR_OFS, 32'h0000_0001);
    i_spf_core_bfm.cmd(8'h09, 4'h2);
    wait_load(8'h30, 8'h3C);
    wr(SPF_ZPTR_OFS, 32'h0000_0000);
    i_spf_core_bfm.cmd(8'h09, 4'h2);
    wait_load(FUSE_LOW, 8'hFF);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset_vec();
    t_filter_irq();
    t_timeout();
    t_busy();
    t_lock();
    stop_test();
  end
endmodule
